// ===== logic/rf_tx_pkg.sv
package rf_tx_pkg;

    // -------------------------------------------------------------------
    // Clock and timing
    // -------------------------------------------------------------------
    localparam int SYS_CLK_HZ   = 10_000_000;
    localparam int WAKE_TIME_US = 500;
    // Wake-up is a least time; the count is taken exact, never below one cycle
    localparam int WAKE_CYCLES  = (WAKE_TIME_US * (SYS_CLK_HZ / 1_000_000) + 0) > 0 ?
                                  WAKE_TIME_US * (SYS_CLK_HZ / 1_000_000) : 1;
    // Idle window is 300 to 500 ms; the middle keeps margin both ways
    localparam int IDLE_TIME_MS = 400;
    localparam int IDLE_CYCLES  = IDLE_TIME_MS * (SYS_CLK_HZ / 1_000);

    // -------------------------------------------------------------------
    // Synthesiser and reference clock
    // -------------------------------------------------------------------
    localparam int PLL_MULT     = 32;
    localparam int XTAL_HZ      = 13_560_000;
    localparam int REF_DIV_LOG2 = 16;
    // Reference is the crystal divided by two to the sixteen; half period in sys_clk cycles
    localparam longint REF_HALF_L = (longint'(SYS_CLK_HZ) << REF_DIV_LOG2) / (2 * XTAL_HZ);
    localparam int REF_HALF_CYCLES = int'(REF_HALF_L);

    // -------------------------------------------------------------------
    // Counter widths and reset values
    // -------------------------------------------------------------------
    localparam int IDLE_W = 23;
    localparam int WAKE_W = 14;
    localparam int REF_W  = 17;
    localparam logic [2:0] SYNC_RESET = 3'h0;

    typedef enum logic [1:0] {ST_STANDBY, ST_WAKE, ST_ACTIVE} tx_state_e;

endpackage

// ===== logic/ref_clk_if.sv
`timescale 1ns/100ps
// Run request towards the reference divider and its output level back
interface ref_clk_if;
    logic run;
    logic level;
    modport ctrl (output run, input level);
    modport gen  (input run, output level);
endinterface

// ===== logic/ref_clock_gen.sv
`timescale 1ns/100ps
module ref_clock_gen
    import rf_tx_pkg::*;
#(
    parameter int HALF_CYCLES = REF_HALF_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    ref_clk_if.gen   port
);

    logic [REF_W-1:0] cnt_q;
    logic             lvl_q;
    wire              half_done = (cnt_q == REF_W'(HALF_CYCLES - 1));

    // -------------------------------------------------------------------
    // Divider: square wave while running, parked low otherwise
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
            lvl_q <= 1'b0;
        end else if (!port.run) begin
            cnt_q <= '0;                       // Restart so each burst opens cleanly
            lvl_q <= 1'b0;
        end else if (half_done) begin
            cnt_q <= '0;
            lvl_q <= ~lvl_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign port.level = lvl_q;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_ref_needs_run: assert property (@(posedge sys_clk) disable iff (reset)
        !port.run |=> !lvl_q)
        else $error("reference pulse without transmission");
    a_ref_half_period: assert property (@(posedge sys_clk) disable iff (reset)
        (port.run && half_done) |=> (lvl_q != $past(lvl_q)) && (cnt_q == '0))
        else $error("reference half period wrong");
    c_ref_toggles: cover property (@(posedge sys_clk) disable iff (reset)
        $rose(lvl_q));

endmodule

// ===== logic/rf_tx_two_line_control.sv
`timescale 1ns/100ps
module rf_tx_two_line_control
    import rf_tx_pkg::*;
#(
    parameter int WAKE_CYCLES_P = WAKE_CYCLES,
    parameter int IDLE_CYCLES_P = IDLE_CYCLES,
    parameter int REF_HALF_P    = REF_HALF_CYCLES,
    parameter int XTAL_HZ_P     = XTAL_HZ
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        tx_data_line,
    output wire logic        ref_clock_out,
    output wire logic        rf_carrier_on,
    output wire logic        pll_on,
    output wire logic        in_standby,
    output wire logic [31:0] carrier_freq_hz
);

    // -------------------------------------------------------------------
    // Data line synchroniser
    // -------------------------------------------------------------------
    logic [2:0]        sync_q;
    logic              data_lvl_q;
    tx_state_e         state_q;
    tx_state_e         state_d;
    logic [IDLE_W-1:0] idle_cnt_q;
    logic [WAKE_W-1:0] wake_cnt_q;
    logic              rf_on_q;
    logic [31:0]       carrier_q;

    // Pin is asynchronous; first stage feeds only the second
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sync_q <= SYNC_RESET;
        end else begin
            sync_q <= {sync_q[1:0], tx_data_line};
        end
    end

    // A change counts once stages two and three agree
    wire stable     = (sync_q[1] == sync_q[2]);
    wire data_edge  = stable && (sync_q[2] != data_lvl_q);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            data_lvl_q <= 1'b0;
        end else if (stable) begin
            data_lvl_q <= sync_q[2];
        end
    end

    // -------------------------------------------------------------------
    // Activity and wake-up timers
    // -------------------------------------------------------------------
    wire idle_done = (idle_cnt_q == IDLE_W'(IDLE_CYCLES_P - 1));
    wire wake_done = (wake_cnt_q == WAKE_W'(WAKE_CYCLES_P - 1));

    // Idle count only runs when powered; it saturates at the limit
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            idle_cnt_q <= '0;
        end else if (data_edge || state_q == ST_STANDBY) begin
            idle_cnt_q <= '0;
        end else if (!idle_done) begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
        end
    end

    // Wake counter holds at its end so a long wake cannot wrap
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wake_cnt_q <= '0;
        end else if (state_q != ST_WAKE) begin
            wake_cnt_q <= '0;
        end else if (!wake_done) begin
            wake_cnt_q <= wake_cnt_q + 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // Power state machine
    // -------------------------------------------------------------------
    // Idle expiry outranks wake completion so a dead line never powers up
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_STANDBY: begin
                if (data_edge) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (idle_done && !data_edge) begin
                    state_d = ST_STANDBY;
                end else if (wake_done) begin
                    state_d = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (idle_done && !data_edge) begin
                    state_d = ST_STANDBY;
                end
            end
            default: begin
                state_d = ST_STANDBY;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_STANDBY;
        end else begin
            state_q <= state_d;
        end
    end

    // -------------------------------------------------------------------
    // Carrier keying and synthesiser
    // -------------------------------------------------------------------
    // Keying waits for the wake-up to finish; data high during wake stays dark
    wire key_now = (state_q == ST_ACTIVE) && data_lvl_q;
    // Synthesiser runs whenever powered; keying only gates the output stage
    wire [31:0] carrier_sel = (state_q != ST_STANDBY) ? 32'(XTAL_HZ_P * PLL_MULT) : 32'h0;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rf_on_q   <= 1'b0;
            carrier_q <= '0;
        end else begin
            rf_on_q   <= key_now;
            carrier_q <= carrier_sel;
        end
    end

    // -------------------------------------------------------------------
    // Reference clock
    // -------------------------------------------------------------------
    // Half period is a parameter of its own; it must be retuned with the crystal
    ref_clk_if ref_bus ();

    // Divider only runs with the carrier, which also parks it low in standby
    assign ref_bus.run = rf_on_q;

    ref_clock_gen #(
        .HALF_CYCLES (REF_HALF_P)
    ) u_ref (
        .sys_clk (sys_clk),
        .reset   (reset),
        .port    (ref_bus.gen)
    );

    // pll_on and in_standby decode the state register and change with it; carrier_freq_hz follows a cycle later
    assign ref_clock_out   = ref_bus.level;
    assign rf_carrier_on   = rf_on_q;
    assign pll_on          = (state_q != ST_STANDBY);
    assign in_standby      = (state_q == ST_STANDBY);
    assign carrier_freq_hz = carrier_q;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_rf_follows_data: assert property (@(posedge sys_clk) disable iff (reset)
        rf_on_q |-> $past(data_lvl_q) && $past(state_q) == ST_ACTIVE)
        else $error("carrier on without high data");
    a_wake_full_delay: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q == ST_ACTIVE && $past(state_q) == ST_WAKE)
        |-> $past(wake_cnt_q) == WAKE_W'(WAKE_CYCLES_P - 1))
        else $error("wake-up delay cut short");
    a_ref_during_tx: assert property (@(posedge sys_clk) disable iff (reset)
        (!rf_on_q)[*2] |-> !ref_clock_out)
        else $error("reference pulse outside transmission");
    a_idle_to_standby: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q != ST_STANDBY && idle_done && !data_edge)
        |=> state_q == ST_STANDBY && !pll_on)
        else $error("idle expiry missed");
    a_ref_low_standby: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q == ST_STANDBY)[*3] |-> !ref_clock_out && !rf_carrier_on)
        else $error("reference not low in standby");
    // Judged on the raw synchroniser so a fault in the held level is caught too
    a_key_low_off: assert property (@(posedge sys_clk) disable iff (reset)
        (!sync_q[2])[*4] |-> !rf_carrier_on)
        else $error("carrier on with data line low");
    a_dark_while_waking: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q == ST_WAKE) |-> !rf_carrier_on)
        else $error("carrier during wake-up");
    a_idle_bounded: assert property (@(posedge sys_clk) disable iff (reset)
        idle_cnt_q <= IDLE_W'(IDLE_CYCLES_P - 1))
        else $error("idle timer ran past its limit");
    a_carrier_mult: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q != ST_STANDBY) |=> carrier_freq_hz == 32'(XTAL_HZ_P * PLL_MULT))
        else $error("carrier not thirty-two times crystal");
    a_edge_restart: assert property (@(posedge sys_clk) disable iff (reset)
        data_edge |=> idle_cnt_q == '0)
        else $error("edge did not restart idle timer");
    a_standby_wakes: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q == ST_STANDBY && data_edge) |=> state_q == ST_WAKE)
        else $error("edge in standby did not wake");

    // Covers for the main scenarios
    c_wake_to_active: cover property (@(posedge sys_clk) disable iff (reset)
        state_q == ST_WAKE ##1 state_q == ST_ACTIVE);
    c_active_to_standby: cover property (@(posedge sys_clk) disable iff (reset)
        state_q == ST_ACTIVE ##1 state_q == ST_STANDBY);
    c_keyed_burst: cover property (@(posedge sys_clk) disable iff (reset)
        $rose(rf_on_q) ##[1:300] $fell(rf_on_q));
    c_rekey_active: cover property (@(posedge sys_clk) disable iff (reset)
        $fell(rf_on_q) ##[1:300] $rose(rf_on_q));

endmodule

// ===== verification/mcu_pin_model.sv
`timescale 1ns/100ps
// Controller pins facing the transmitter: key line out, reference line in
module mcu_pin_model (
    input  wire logic        sys_clk,
    input  wire logic        want_level,
    input  wire logic        sleep_req,
    input  wire logic        ref_clock_out,  // Pin kept as an input
    output logic             tx_data_line,
    output logic [15:0]      half_meas
);
    logic [15:0] cnt_q;
    logic        ref_q;

    // Key line driven from time zero so the transmitter never starts undefined
    initial begin
        tx_data_line = 1'b0;
        cnt_q = 16'h0;
        ref_q = 1'b0;
        half_meas = 16'h0;
    end

    // Key forced low ahead of controller sleep so the far side can idle
    always @(posedge sys_clk) begin
        tx_data_line <= #10 sleep_req ? 1'b0 : want_level;
    end

    // Half periods of the reference timed in sys_clk cycles for RC trimming
    always @(posedge sys_clk) begin
        cnt_q <= (ref_clock_out != ref_q) ? 16'h1 : cnt_q + 16'h1;
        if (ref_clock_out != ref_q) begin
            half_meas <= cnt_q;
        end
        ref_q <= ref_clock_out;
    end
endmodule

// ===== verification/rf_tx_two_line_control_test.sv
`timescale 1ns/100ps
module rf_tx_two_line_control_test
    import rf_tx_pkg::*;
;
    typedef struct {string what; int sel; logic [31:0] val;} note_s;

    logic        sys_clk;
    logic        reset;
    logic        want_level;
    logic        sleep_req;
    logic        tx_data_line;
    logic        ref_clock_out;
    logic        rf_carrier_on;
    logic        pll_on;
    logic        in_standby;
    logic [31:0] carrier_freq_hz;
    logic [15:0] half_meas;
    logic [31:0] rnd;
    note_s       notes[$];
    int          error_cnt = 0;
    int          checks = 0;

    // Short counts keep the run brief; expectations follow these values
    rf_tx_two_line_control #(.WAKE_CYCLES_P(20), .IDLE_CYCLES_P(200), .REF_HALF_P(5)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .tx_data_line(tx_data_line),
        .ref_clock_out(ref_clock_out), .rf_carrier_on(rf_carrier_on), .pll_on(pll_on),
        .in_standby(in_standby), .carrier_freq_hz(carrier_freq_hz));

    mcu_pin_model u_mcu (
        .sys_clk(sys_clk), .want_level(want_level), .sleep_req(sleep_req),
        .ref_clock_out(ref_clock_out), .tx_data_line(tx_data_line), .half_meas(half_meas));

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] pick(input int sel);
        case (sel)
            0: return {31'h0, rf_carrier_on};
            1: return {31'h0, ref_clock_out};
            2: return {31'h0, pll_on};
            3: return {31'h0, in_standby};
            4: return carrier_freq_hz;
            default: return {16'h0, half_meas};
        endcase
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask

    task automatic note(input string what, input int sel, input logic [31:0] v);
        notes.push_back('{what, sel, v});
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Clock and hang guard; the run needs under 2000 cycles
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial begin
        #400000;
        error_cnt++;
        report_and_stop;
    end

    // Every queued note is compared, oldest first, once the outputs have settled
    initial begin
        note_s n;
        forever begin
            @(negedge sys_clk);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                check(n.what, pick(n.sel), n.val);
            end
        end
    end

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    initial begin
        reset = 1'b1;
        want_level = 1'b0;
        sleep_req = 1'b0;
        rnd = 32'h1891ea93;
        cyc(16);
        reset = 1'b0;
        cyc(2);
        note("standby", 3, 32'h1);
        note("ref", 1, 32'h0);
        note("pll", 2, 32'h0);
        $display("test reset done");
        // One-cycle pulse is too short to wake
        want_level = 1'b1;
        cyc(1);
        want_level = 1'b0;
        cyc(30);
        note("standby", 3, 32'h1);
        note("carrier", 0, 32'h0);
        $display("test glitch done");
        want_level = 1'b1;
        cyc(21);
        note("carrier", 0, 32'h0);
        note("pll", 2, 32'h1);
        note("freq", 4, 32'(XTAL_HZ * PLL_MULT));
        cyc(10);
        note("carrier", 0, 32'h1);
        cyc(30);
        note("half", 5, 32'h5);
        $display("test wake done");
        want_level = 1'b0;
        cyc(10);
        note("carrier", 0, 32'h0);
        note("ref", 1, 32'h0);
        note("pll", 2, 32'h1);
        // Re-key outside standby has no wake delay
        want_level = 1'b1;
        cyc(10);
        note("carrier", 0, 32'h1);
        $display("test rekey done");
        repeat (4) begin
            want_level = ~want_level;
            cyc(150);
        end
        note("pll", 2, 32'h1);
        $display("test activity done");
        repeat (20) begin
            rnd = lfsr(rnd);
            want_level = ~want_level;
            cyc(10 + int'(rnd[4:0]));
            note("carrier", 0, {31'h0, want_level});
        end
        $display("test random done");
        want_level = 1'b1;
        cyc(30);
        sleep_req = 1'b1;
        cyc(150);
        note("pll", 2, 32'h1);
        cyc(80);
        note("standby", 3, 32'h1);
        note("freq", 4, 32'h0);
        note("ref", 1, 32'h0);
        note("carrier", 0, 32'h0);
        cyc(2);
        $display("test sleep done");
        report_and_stop;
    end
endmodule
